// [logic/i2crs_pkg.sv]
// Purpose: Shared constants and carriers for the range-address and SMBus timeout block.
// Assumes: An 8-bit register file behind a 32-bit AXI4-Lite slave, one word per register.
// Notes:   Register indices are word indices; the byte address is four times the index.

// ==================================================================
// Package
package i2crs_pkg;

    localparam int         AXI_ADDR_W = 8;
    localparam int         AXI_DATA_W = 32;

    // Register word indices.
    localparam logic [3:0] IDX_RANGE  = 4'h7;
    localparam logic [3:0] IDX_SMBCS  = 4'h8;
    localparam logic [3:0] IDX_ADDR2  = 4'h9;
    localparam logic [3:0] IDX_LT_HI  = 4'ha;
    localparam logic [3:0] IDX_LT_LO  = 4'hb;
    localparam logic [3:0] IDX_AUX    = 4'hc;

    // Control and status field positions.
    localparam int         FLD_IACK   = 7;
    localparam int         FLD_ALERT  = 6;
    localparam int         FLD_SADEN  = 5;
    localparam int         FLD_TOCSEL = 4;
    localparam int         FLD_LOWF   = 3;
    localparam int         FLD_IDLE   = 2;
    localparam int         FLD_SHSL   = 1;
    localparam int         FLD_SHSLIE = 0;
    localparam int         FLD_RGEN   = 0;
    localparam int         FLD_ACKV   = 1;

    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [6:0] RST_ADDR7  = 7'h00;
    localparam logic [6:0] ARA_ADDR   = 7'h0c;

    // Timeout counter clock: module clock divided by 64, or undivided.
    localparam int         PRE_W      = 6;
    localparam logic [5:0] PRE_LAST   = 6'h3f;
    localparam int         LT_W       = 16;
    localparam int         HIGH_SHIFT = 9;

    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
    } i2crs_addr_s;

    typedef struct packed {
        logic strobe;
        logic nack;
    } i2crs_ack_s;

    typedef struct packed {
        logic range;
        logic alert;
        logic second;
    } i2crs_hit_s;

endpackage

// [logic/i2crs_dur_cnt.sv]
// Purpose: Measures how long a bus condition holds, in timeout counter ticks.
// Assumes: cond_i is synchronous to clk_i; tick_i is a one-cycle enable.
// Notes:   The count restarts whenever the condition drops.
`timescale 1ns/1ps
`default_nettype none

module i2crs_dur_cnt #(
    parameter int CNT_W = 16
) (
    input  wire logic             clk_i,   // Module clock.
    input  wire logic             rst_i,   // Synchronous reset, active high.
    input  wire logic             cond_i,  // Condition being timed.
    input  wire logic             en_i,    // Detection enabled.
    input  wire logic             tick_i,  // Counter clock tick.
    input  wire logic [CNT_W-1:0] limit_i, // Ticks the condition may last.
    output logic                  over_o,  // Condition lasted longer than the limit.
    output logic                  fire_o   // One-cycle pulse when over_o rises.
);

    logic [CNT_W-1:0] cnt_q;
    logic             at_limit;

    assign at_limit = (cnt_q == limit_i);

    // ==================================================================
    // Counter
    always_ff @(posedge clk_i) begin
        if (rst_i || !cond_i || !en_i) begin
            cnt_q  <= '0;
            over_o <= 1'b0;
            fire_o <= 1'b0;
        end else begin
            fire_o <= tick_i && !over_o && at_limit;
            if (tick_i && !over_o && at_limit) begin
                over_o <= 1'b1;
            end else if (tick_i && !over_o) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    // ==================================================================
    // Checks
    chk_restart_on_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        !cond_i |=> (cnt_q == '0) && !over_o)
        else $error("Duration count did not restart when the condition dropped.");

endmodule

`default_nettype wire

// [logic/i2crs_top.sv]
// Purpose: Range address matching, SMBus address enables, fast ACK and bus timeouts.
// Assumes: scl_i and sda_i are already synchronous and filtered; the byte engine
//          outside presents received addresses and received-byte events.
// Notes:   Registers sit behind an AXI4-Lite slave, one 8-bit register per word.
//
// How it works
// - Range upper address held in bits seven down.
// - Range register bit zero reads zero always.
// - Nonzero write with range enable activates matching.
// - Range address is the top accepted address.
// - Idle flag: both lines high past threshold.
// - Bus counts free while both lines high.
// - Fast ACK waits for software ACK choice.
// - Alert response address matches only when enabled.
// - Second address compared only when enabled.
// - Timeout clock: module clock or divided by 64.
// - SCL low timeout sets flag; write one clears.
// - Zero low timeout value disables low detection.
// - SCL high SDA low timeout flag; write clears.
// - High-low timeout interrupt gated by its enable.
// - Low timeout built from high and low bytes.
// - Second address register holds seven-bit address.
`timescale 1ns/1ps
`default_nettype none

module i2crs_top #(
    parameter int ADDR_W = i2crs_pkg::AXI_ADDR_W,
    parameter int DATA_W = i2crs_pkg::AXI_DATA_W
) (
    input  wire logic                   clk_i,        // Module clock, 200 MHz.
    input  wire logic                   rst_i,        // Synchronous reset, active high.
    input  wire logic [ADDR_W-1:0]      s_awaddr_i,   // Write address.
    input  wire logic                   s_awvalid_i,  // Write address valid.
    output logic                        s_awready_o,  // Write address ready.
    input  wire logic [DATA_W-1:0]      s_wdata_i,    // Write data.
    input  wire logic [DATA_W/8-1:0]    s_wstrb_i,    // Write byte enables.
    input  wire logic                   s_wvalid_i,   // Write data valid.
    output logic                        s_wready_o,   // Write data ready.
    output logic [1:0]                  s_bresp_o,    // Write response.
    output logic                        s_bvalid_o,   // Write response valid.
    input  wire logic                   s_bready_i,   // Write response ready.
    input  wire logic [ADDR_W-1:0]      s_araddr_i,   // Read address.
    input  wire logic                   s_arvalid_i,  // Read address valid.
    output logic                        s_arready_o,  // Read address ready.
    output logic [DATA_W-1:0]           s_rdata_o,    // Read data.
    output logic [1:0]                  s_rresp_o,    // Read response.
    output logic                        s_rvalid_o,   // Read data valid.
    input  wire logic                   s_rready_i,   // Read data ready.
    input  wire logic                   scl_i,        // Bus clock line level.
    input  wire logic                   sda_i,        // Bus data line level.
    input  wire logic [6:0]             base_addr_i,  // Lower bound of the range.
    input  wire i2crs_pkg::i2crs_addr_s addr_req_i,   // Received address to match.
    input  wire logic                   byte_rcvd_i,  // Data byte received pulse.
    output i2crs_pkg::i2crs_hit_s       hit_o,        // Address match pulses.
    output i2crs_pkg::i2crs_ack_s       ack_o,        // ACK/NACK command pulse.
    output logic                        bus_free_o,   // Bus seen free by a master.
    output logic                        irq_o         // High-low timeout interrupt.
);

    // ==================================================================
    // Register bus decode
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [3:0] i;
        i = a[5:2];
        return (a[1:0] == 2'h0) && (a[ADDR_W-1:6] == '0) &&
               (i >= i2crs_pkg::IDX_RANGE) && (i <= i2crs_pkg::IDX_AUX);
    endfunction

    logic [ADDR_W-1:0] aw_addr_q;
    logic              aw_full_q;
    logic [7:0]        w_data_q;
    logic              w_strb_q;
    logic              w_full_q;
    logic              do_write;
    logic              aw_full_d;
    logic              w_full_d;
    logic              bvalid_d;
    logic              wr_ok;
    logic [3:0]        wr_idx;
    logic              wr_range;
    logic              wr_smb;
    logic              wr_addr2;
    logic              wr_lt_hi;
    logic              wr_lt_lo;
    logic              wr_aux;
    logic              rd_take;
    logic [3:0]        rd_idx;
    logic [7:0]        rd_byte;

    assign do_write  = aw_full_q && w_full_q && !s_bvalid_o;
    assign aw_full_d = !do_write && (aw_full_q || (s_awvalid_i && s_awready_o));
    assign w_full_d  = !do_write && (w_full_q || (s_wvalid_i && s_wready_o));
    assign bvalid_d  = do_write || (s_bvalid_o && !s_bready_i);
    assign wr_ok     = do_write && is_mapped(aw_addr_q) && w_strb_q;
    assign wr_idx    = aw_addr_q[5:2];
    assign wr_range  = wr_ok && (wr_idx == i2crs_pkg::IDX_RANGE);
    assign wr_smb    = wr_ok && (wr_idx == i2crs_pkg::IDX_SMBCS);
    assign wr_addr2  = wr_ok && (wr_idx == i2crs_pkg::IDX_ADDR2);
    assign wr_lt_hi  = wr_ok && (wr_idx == i2crs_pkg::IDX_LT_HI);
    assign wr_lt_lo  = wr_ok && (wr_idx == i2crs_pkg::IDX_LT_LO);
    assign wr_aux    = wr_ok && (wr_idx == i2crs_pkg::IDX_AUX);
    assign rd_take   = s_arvalid_i && s_arready_o;
    assign rd_idx    = s_araddr_i[5:2];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_full_q   <= 1'b0;
            w_full_q    <= 1'b0;
            aw_addr_q   <= '0;
            w_data_q    <= i2crs_pkg::RST_BYTE;
            w_strb_q    <= 1'b0;
            s_awready_o <= 1'b1;
            s_wready_o  <= 1'b1;
            s_bvalid_o  <= 1'b0;
            s_bresp_o   <= i2crs_pkg::RESP_OKAY;
        end else begin
            aw_full_q   <= aw_full_d;
            w_full_q    <= w_full_d;
            s_awready_o <= !aw_full_d;
            s_wready_o  <= !w_full_d;
            s_bvalid_o  <= bvalid_d;
            if (s_awvalid_i && s_awready_o) begin
                aw_addr_q <= s_awaddr_i;
            end
            if (s_wvalid_i && s_wready_o) begin
                w_data_q <= s_wdata_i[7:0];
                w_strb_q <= s_wstrb_i[0];
            end
            if (do_write) begin
                s_bresp_o <= is_mapped(aw_addr_q) ? i2crs_pkg::RESP_OKAY
                                                  : i2crs_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_arready_o <= 1'b1;
            s_rvalid_o  <= 1'b0;
            s_rdata_o   <= '0;
            s_rresp_o   <= i2crs_pkg::RESP_OKAY;
        end else if (rd_take) begin
            s_arready_o <= 1'b0;
            s_rvalid_o  <= 1'b1;
            s_rdata_o   <= {{(DATA_W-8){1'b0}}, is_mapped(s_araddr_i) ? rd_byte : 8'h00};
            s_rresp_o   <= is_mapped(s_araddr_i) ? i2crs_pkg::RESP_OKAY
                                                 : i2crs_pkg::RESP_SLVERR;
        end else if (s_rvalid_o && s_rready_i) begin
            s_arready_o <= 1'b1;
            s_rvalid_o  <= 1'b0;
        end
    end

    // ==================================================================
    // Registers
    logic [6:0]  range_addr_q;
    logic        range_active_q;
    logic        iack_q;
    logic        alert_q;
    logic        saden_q;
    logic        tocsel_q;
    logic        lowf_q;
    logic        shsl_q;
    logic        shslie_q;
    logic [6:0]  addr2_q;
    logic [7:0]  lt_hi_q;
    logic [7:0]  lt_lo_q;
    logic        rgen_q;
    logic        ackv_q;
    logic        idle_flag;
    logic        low_fire;
    logic        hs_fire;
    logic        lowf_d;
    logic        shsl_d;
    logic [15:0] lt_val;

    assign lt_val = {lt_hi_q, lt_lo_q};
    // A new timeout event wins over a write-one clear in the same cycle.
    assign lowf_d = low_fire || (lowf_q && !(wr_smb && w_data_q[i2crs_pkg::FLD_LOWF]));
    assign shsl_d = hs_fire || (shsl_q && !(wr_smb && w_data_q[i2crs_pkg::FLD_SHSL]));

    assign rd_byte =
        (rd_idx == i2crs_pkg::IDX_RANGE) ? {range_addr_q, 1'b0} :
        (rd_idx == i2crs_pkg::IDX_SMBCS) ? {iack_q, alert_q, saden_q, tocsel_q,
                                            lowf_q, idle_flag, shsl_q, shslie_q} :
        (rd_idx == i2crs_pkg::IDX_ADDR2) ? {addr2_q, 1'b0} :
        (rd_idx == i2crs_pkg::IDX_LT_HI) ? lt_hi_q :
        (rd_idx == i2crs_pkg::IDX_LT_LO) ? lt_lo_q :
        {6'h00, ackv_q, rgen_q};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            range_addr_q   <= i2crs_pkg::RST_ADDR7;
            range_active_q <= 1'b0;
            {iack_q, alert_q, saden_q, tocsel_q} <= 4'h0;
            shslie_q       <= 1'b0;
            lowf_q         <= 1'b0;
            shsl_q         <= 1'b0;
            addr2_q        <= i2crs_pkg::RST_ADDR7;
            lt_hi_q        <= i2crs_pkg::RST_BYTE;
            lt_lo_q        <= i2crs_pkg::RST_BYTE;
            rgen_q         <= 1'b0;
            ackv_q         <= 1'b0;
        end else begin
            lowf_q <= lowf_d;
            shsl_q <= shsl_d;
            if (wr_range) begin
                range_addr_q   <= w_data_q[7:1];
                range_active_q <= rgen_q && (w_data_q != 8'h00);
            end
            if (wr_smb) begin
                iack_q   <= w_data_q[i2crs_pkg::FLD_IACK];
                alert_q  <= w_data_q[i2crs_pkg::FLD_ALERT];
                saden_q  <= w_data_q[i2crs_pkg::FLD_SADEN];
                tocsel_q <= w_data_q[i2crs_pkg::FLD_TOCSEL];
                shslie_q <= w_data_q[i2crs_pkg::FLD_SHSLIE];
            end
            if (wr_addr2) begin
                addr2_q <= w_data_q[7:1];
            end
            if (wr_lt_hi) begin
                lt_hi_q <= w_data_q;
            end
            if (wr_lt_lo) begin
                lt_lo_q <= w_data_q;
            end
            if (wr_aux) begin
                rgen_q <= w_data_q[i2crs_pkg::FLD_RGEN];
                ackv_q <= w_data_q[i2crs_pkg::FLD_ACKV];
            end
        end
    end

    // ==================================================================
    // Timeout counters
    logic [i2crs_pkg::PRE_W-1:0] pre_q;
    logic                        tick;
    logic [2:0]                  cond_v;
    logic [2:0]                  en_v;
    logic [2:0]                  over_v;
    logic [2:0]                  fire_v;
    logic [i2crs_pkg::LT_W-1:0]  lim_v [3];
    logic [i2crs_pkg::LT_W-1:0]  high_lim;

    assign tick     = tocsel_q || (pre_q == i2crs_pkg::PRE_LAST);
    assign high_lim = lt_val >> i2crs_pkg::HIGH_SHIFT;
    // Index 0: both lines high, 1: SCL high with SDA low, 2: SCL low.
    assign cond_v   = {!scl_i, scl_i && !sda_i, scl_i && sda_i};
    assign en_v     = {lt_val != 16'h0000, 2'b11};
    assign lim_v[0] = high_lim;
    assign lim_v[1] = high_lim;
    assign lim_v[2] = lt_val;
    assign idle_flag = over_v[0];
    assign hs_fire  = fire_v[1];
    assign low_fire = fire_v[2];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_dur
        i2crs_dur_cnt #(
            .CNT_W (i2crs_pkg::LT_W)
        ) u_cnt (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .cond_i  (cond_v[g]),
            .en_i    (en_v[g]),
            .tick_i  (tick),
            .limit_i (lim_v[g]),
            .over_o  (over_v[g]),
            .fire_o  (fire_v[g])
        );
    end

    // ==================================================================
    // Address matching, acknowledge control and outputs
    i2crs_pkg::i2crs_hit_s hit_d;
    logic                  ack_pend_q;

    assign hit_d.range  = addr_req_i.valid && rgen_q && range_active_q &&
                          (addr_req_i.addr >= base_addr_i) &&
                          (addr_req_i.addr <= range_addr_q);
    assign hit_d.alert  = addr_req_i.valid && alert_q &&
                          (addr_req_i.addr == i2crs_pkg::ARA_ADDR);
    assign hit_d.second = addr_req_i.valid && saden_q &&
                          (addr_req_i.addr == addr2_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hit_o      <= '0;
            ack_o      <= '0;
            ack_pend_q <= 1'b0;
            bus_free_o <= 1'b0;
            irq_o      <= 1'b0;
        end else begin
            hit_o      <= hit_d;
            // Measuring the idle time still counts as a free bus for arbitration.
            bus_free_o <= scl_i && sda_i;
            irq_o      <= shsl_q && shslie_q;
            if (byte_rcvd_i && !iack_q) begin
                ack_o <= '{strobe: 1'b1, nack: ackv_q};
            end else if (wr_aux && ack_pend_q) begin
                ack_o      <= '{strobe: 1'b1, nack: w_data_q[i2crs_pkg::FLD_ACKV]};
                ack_pend_q <= 1'b0;
            end else begin
                ack_o <= '0;
            end
            if (byte_rcvd_i && iack_q) begin
                ack_pend_q <= 1'b1;
            end
        end
    end

    // ==================================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_range_read_lsb: assert property (
        rd_take && is_mapped(s_araddr_i) && rd_idx == i2crs_pkg::IDX_RANGE
        |=> s_rdata_o[0] == 1'b0 && s_rdata_o[7:1] == $past(range_addr_q))
        else $error("Range register read back wrong.");
    chk_range_activate: assert property (
        wr_range && rgen_q && w_data_q != 8'h00 |=> range_active_q)
        else $error("Nonzero range write did not activate matching.");
    chk_range_upper: assert property (
        addr_req_i.valid && addr_req_i.addr > range_addr_q |=> !hit_o.range)
        else $error("Address above the range upper bound matched.");
    chk_idle_clears: assert property (!(scl_i && sda_i) |=> !idle_flag)
        else $error("Idle flag did not clear when a line went low.");
    chk_bus_free: assert property (scl_i && sda_i |=> bus_free_o)
        else $error("Bus not reported free while both lines high.");
    chk_fast_ack_wait: assert property (byte_rcvd_i && iack_q && !wr_aux |=>
        !ack_o.strobe && ack_pend_q)
        else $error("Fast ACK mode answered without a software choice.");
    chk_alert_gate: assert property (addr_req_i.valid && !alert_q |=> !hit_o.alert)
        else $error("Alert response address matched while disabled.");
    chk_second_gate: assert property (addr_req_i.valid && !saden_q |=> !hit_o.second)
        else $error("Second address matched while disabled.");
    chk_prescale_tick: assert property (tick && !tocsel_q |-> pre_q == i2crs_pkg::PRE_LAST)
        else $error("Divided timeout clock ticked off its period.");
    chk_low_disabled: assert property (lt_val == 16'h0000 |=> !over_v[2])
        else $error("Low timeout detected with zero timeout value.");
    chk_low_flag_cause: assert property ($rose(lowf_q) |-> $past(low_fire))
        else $error("Low timeout flag set without a timeout.");
    chk_shsl_sets: assert property (hs_fire |=> shsl_q)
        else $error("High-low timeout did not set its flag.");
    chk_irq_gate: assert property (
        (shsl_q && shslie_q) ##1 (shsl_q && shslie_q) |-> irq_o)
        else $error("Interrupt missing while flag and enable are set.");
    chk_irq_masked: assert property (!shslie_q |=> !irq_o)
        else $error("Interrupt raised while disabled.");

    cov_range_hit:  cover property (hit_o.range);
    cov_fast_ack:   cover property (ack_pend_q ##1 ack_o.strobe);
    cov_low_flag:   cover property ($rose(lowf_q));
    cov_irq:        cover property ($rose(irq_o));

endmodule

`default_nettype wire

// [sim/i2crs_bus_model.sv]
// Purpose: Far-side bus model giving line levels, addresses and bytes.
// Assumes: Pull-ups hold both lines high whenever they are released.
// Notes:   hold returns on the edge at which it releases the lines; put returns one edge after it clears its outputs.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bus model
module i2crs_bus_model (
    input  wire logic              clk_i, // Module clock.
    output logic                   scl_o, // Clock line.
    output logic                   sda_o, // Data line.
    output i2crs_pkg::i2crs_addr_s adr_o, // Received address.
    output logic                   byt_o  // Byte received.
);
    initial {scl_o, sda_o, adr_o, byt_o} = 11'h600;
    task automatic hold(input logic c, input logic d, input int n);
        {scl_o, sda_o} <= {c, d};
        repeat (n) @(posedge clk_i);
        {scl_o, sda_o} <= 2'h3;
    endtask
    task automatic put(input logic [7:0] v, input logic b);
        {adr_o, byt_o} <= {v, b};
        @(posedge clk_i);
        {adr_o, byt_o} <= 9'h0;
        @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
// Purpose: Self-checking bench for range matching, SMBus enables and timeouts.
// Assumes: The bus model supplies line levels, addresses and bytes.
// Notes:   Short limits with the undivided tick keep timeout runs brief.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module tb;
    logic                   clk, rst, awvalid, wvalid, bready, arvalid, rready, irq, free, nk;
    logic                   awready, wready, bvalid, arready, rvalid, scl, sda, brx;
    logic [7:0]             awaddr, araddr, m[16];
    logic [31:0]            wdata, rdata, got, seed;
    logic [1:0]             bresp, rresp, rsp;
    logic [6:0]             base, a;
    i2crs_pkg::i2crs_addr_s adr;
    i2crs_pkg::i2crs_hit_s  hit;
    i2crs_pkg::i2crs_ack_s  ack;
    int                     errors, checked, cyc, acks, na;
    i2crs_top i_i2crs_top (.clk_i(clk), .rst_i(rst), .s_awaddr_i(awaddr),
        .s_awvalid_i(awvalid), .s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(4'hf),
        .s_wvalid_i(wvalid), .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid),
        .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid),
        .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid),
        .s_rready_i(rready), .scl_i(scl), .sda_i(sda), .base_addr_i(base), .addr_req_i(adr),
        .byte_rcvd_i(brx), .hit_o(hit), .ack_o(ack), .bus_free_o(free), .irq_o(irq));
    i2crs_bus_model m_bus (.clk_i(clk), .scl_o(scl), .sda_o(sda), .adr_o(adr), .byt_o(brx));
    // The acknowledge strobe stands one cycle, so it is counted where it is settled.
    always @(negedge clk) begin
        if (ack.strobe) {acks, nk} <= {acks + 1, ack.nack};
    end
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Register model keeps only the stored bits; flags are expected per scenario.
    task automatic xfer(input logic w, input logic [3:0] i, input logic [7:0] d);
        {awaddr, araddr, wdata} <= {2'h0, i, 2'h0, 2'h0, i, 2'h0, 24'h0, d};
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, ~w, ~w};
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (arready) arvalid <= 1'h0;
        end while (!(w ? bvalid : rvalid));
        {bready, rready} <= 2'h0;
        {got, rsp} = {rdata, w ? bresp : rresp};
        if (w) m[i] = d & (i == 8 ? 8'hf1 : i == 12 ? 8'h03 : i == 7 || i == 9 ? 8'hfe : 8'hff);
        @(posedge clk);
    endtask
    task automatic rc(input logic [3:0] i, input logic [7:0] k, input logic [7:0] e);
        xfer(1'h0, i, 8'h0);
        chk(got & {24'h0, k}, {24'h0, e & k});
    endtask
    task automatic send(input logic [6:0] v, input logic [2:0] e);
        m_bus.put({1'h1, v}, 1'h0);
        chk({29'h0, hit}, {29'h0, e});
    endtask
    task automatic tmo(input logic [1:0] l, input int n, input logic [7:0] k, input logic [7:0] e);
        m_bus.hold(l[1], l[0], n);
        repeat (3) @(posedge clk);
        rc(4'h8, k, e);
    endtask
    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, base, seed} = {55'h0, 32'h7ca45da0};
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        for (int i = 7; i < 13; i++) begin
            rc(i[3:0], 8'hfb, 8'h0);
            got = rnd();
            xfer(1'h1, i[3:0], got[7:0]);
            rc(i[3:0], 8'hfb, m[i]);
        end
        xfer(1'h1, 4'hf, 8'h1);
        chk({30'h0, rsp}, 32'h2);
        xfer(1'h0, 4'hf, 8'h0);
        chk({rsp, got[29:0]}, 32'h80000000);
        for (int i = 7; i < 13; i++) xfer(1'h1, i[3:0], 8'h0);
        $display("register test done");
        base <= 7'h10;
        xfer(1'h1, 4'hc, 8'h1);
        xfer(1'h1, 4'h7, 8'h41);
        for (int n = 0; n < 24; n++) begin
            got = rnd();
            a = n < 2 ? 7'h0f + 7'(n) : n < 4 ? 7'h1e + 7'(n) : {1'h0, got[5:0]};
            send(a, {a >= 7'h10 && a <= 7'h20, 2'h0});
        end
        xfer(1'h1, 4'h7, 8'h0);
        send(7'h18, 3'h0);
        xfer(1'h1, 4'hc, 8'h0);
        xfer(1'h1, 4'h7, 8'h40);
        xfer(1'h1, 4'hc, 8'h1);
        send(7'h18, 3'h0);
        $display("range test done");
        xfer(1'h1, 4'h9, 8'h55);
        for (int e = 0; e < 2; e++) begin
            xfer(1'h1, 4'h8, e[0] ? 8'h60 : 8'h00);
            send(7'h0c, {1'h0, e[0], 1'h0});
            send(7'h2a, {2'h0, e[0]});
        end
        for (int t = 0; t < 4; t++) begin
            xfer(1'h1, 4'h8, {t[1], 7'h0});
            xfer(1'h1, 4'hc, {6'h0, t[0], 1'h0});
            m_bus.put(8'h0, 1'h1);
            chk({30'h0, ack}, {30'h0, ~t[1], t[0] & ~t[1]});
            if (t[1]) begin
                na = acks;
                xfer(1'h1, 4'hc, {6'h0, ~t[0], 1'h0});
                chk(acks - na, 32'h1);
                chk({31'h0, nk}, {31'h0, ~t[0]});
            end
        end
        $display("address and ack tests done");
        xfer(1'h1, 4'h8, 8'h10);
        xfer(1'h1, 4'hb, 8'h3);
        tmo(2'h1, 3, 8'h08, 8'h00);
        tmo(2'h1, 3, 8'h08, 8'h00);
        tmo(2'h1, 10, 8'h08, 8'h08);
        xfer(1'h1, 4'h8, 8'h18);
        rc(4'h8, 8'h08, 8'h00);
        xfer(1'h1, 4'hb, 8'h0);
        tmo(2'h1, 40, 8'h08, 8'h00);
        xfer(1'h1, 4'h8, 8'h00);
        xfer(1'h1, 4'hb, 8'h1);
        tmo(2'h1, 60, 8'h08, 8'h00);
        tmo(2'h1, 200, 8'h08, 8'h08);
        xfer(1'h1, 4'h8, 8'h19);
        xfer(1'h1, 4'ha, 8'h4);
        xfer(1'h1, 4'hb, 8'h0);
        tmo(2'h2, 2, 8'h0a, 8'h00);
        tmo(2'h2, 12, 8'h0a, 8'h02);
        chk({31'h0, irq}, 32'h1);
        xfer(1'h1, 4'h8, 8'h12);
        tmo(2'h2, 12, 8'h02, 8'h02);
        chk({31'h0, irq}, 32'h0);
        $display("timeout tests done");
        xfer(1'h1, 4'h8, 8'h02);
        m_bus.hold(1'h0, 1'h1, 4);
        chk({31'h0, free}, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, free}, 32'h1);
        rc(4'h8, 8'h04, 8'h00);
        repeat (300) @(posedge clk);
        rc(4'h8, 8'h04, 8'h04);
        $display("idle test done");
        end_sim();
    end
endmodule
`default_nettype wire
